/* verilog/scpr_serial_port.sv */
`timescale 1ns/1ps

// Functional notes
// - Reads of one to three bytes shift eight bits per byte from the start address.
// - Streaming reads continue byte after byte until chip select rises or address 0x232 has been accessed.
// - Streaming visits reserved and blank addresses, never skipping any.
// - Each readback bit changes on a falling shift-clock edge.
// - Readback uses the shared data pin, or the separate pin when config bit 0 set.
// - Readback control bit 0 picks active registers over staged buffer contents.
// - Register space covers addresses 0x000 up to 0x232.
// - Instruction: bit 15 read flag, bits 14:13 length code, bits 12:0 address.
// - Length code 00/01/10 gives one/two/three bytes, 11 streams.
// - Only the low ten address bits select a register.
// - Port configuration resets to 0x18.
// - After reset, shifting is most significant bit first.
// - The LSB-first bits take effect at once, without update.
// - MSB-first: start at the high byte, address decrements per byte.
// - LSB-first: start at the low byte, address increments per byte.
// - Incrementing stream ends after accessing 0x232.
// - Decrementing stream wraps from 0x000 to 0x232, accesses it, stops.
// - Write and instruction bits are sampled on rising shift-clock edges.
// - Both data pins float while chip select is high.
// - Writing 1 to bit 0 of 0x232 copies buffer to active; bit self-clears.

module scpr_serial_port (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic ce,
	// Serial link from the host
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic sdio_in,
	// Shared data pin drive
	output logic      sdio_out,
	output logic      sdio_oe_n,
	// Separate readback pin drive
	output logic      readback_out_pin,
	output logic      readback_out_oe_n
);
	import scpr_pkg::*;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic sclk_s;
	logic cs_n_s;
	logic sdi_s;

	scpr_sync #(
		.WIDTH (1),
		.INIT  (1'b0)
	) u_sync_sclk (
		.clock    (clock),
		.rst_n    (rst_n),
		.ce       (ce),
		.async_in (sclk),
		.sync_out (sclk_s)
	);

	scpr_sync #(
		.WIDTH (1),
		.INIT  (1'b1)
	) u_sync_cs (
		.clock    (clock),
		.rst_n    (rst_n),
		.ce       (ce),
		.async_in (cs_n),
		.sync_out (cs_n_s)
	);

	scpr_sync #(
		.WIDTH (1),
		.INIT  (1'b0)
	) u_sync_sdi (
		.clock    (clock),
		.rst_n    (rst_n),
		.ce       (ce),
		.async_in (sdio_in),
		.sync_out (sdi_s)
	);

	// ************************************************************
	// Shift clock edge detection
	// ************************************************************
	logic sclk_prev_q;
	logic sclk_prev_d;
	logic sclk_rise;
	logic sclk_fall;

	always_comb begin
		sclk_prev_d = ce ? sclk_s : sclk_prev_q;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_prev_d;
		end
	end

	assign sclk_rise = ce && sclk_s && !sclk_prev_q;
	assign sclk_fall = ce && !sclk_s && sclk_prev_q;

	// ************************************************************
	// Register file
	// ************************************************************
	logic                   wr_en;
	logic [SCPR_ADDR_W-1:0] wr_addr;
	logic [7:0]             wr_data;
	logic [7:0]             rd_data;
	logic [7:0]             port_cfg;
	logic [SCPR_ADDR_W-1:0] addr_q;
	logic                   lsb_first;
	logic                   separate_output_enable;

	scpr_regfile #(
		.DEPTH (SCPR_REG_COUNT)
	) u_regs (
		.clock    (clock),
		.rst_n    (rst_n),
		.ce       (ce),
		.wr_en    (wr_en),
		.wr_addr  (wr_addr),
		.wr_data  (wr_data),
		.rd_addr  (addr_q),
		.rd_data  (rd_data),
		.port_cfg (port_cfg)
	);

	// The reset value has both order bits clear, so MSB first holds after reset.
	assign lsb_first = port_cfg[SCPR_CFG_LSB_BIT] | port_cfg[SCPR_CFG_LSB_MBIT];
	assign separate_output_enable = port_cfg[SCPR_CFG_SEP_BIT];

	// ************************************************************
	// Transfer state
	// ************************************************************
	scpr_state_e            state_q;
	scpr_state_e            state_d;
	logic [3:0]             cnt_q;
	logic [3:0]             cnt_d;
	logic [15:0]            sh_q;
	logic [15:0]            sh_d;
	logic [7:0]             wbyte_q;
	logic [7:0]             wbyte_d;
	logic                   rd_q;
	logic                   rd_d;
	logic                   stream_q;
	logic                   stream_d;
	logic [1:0]             left_q;
	logic [1:0]             left_d;
	logic [SCPR_ADDR_W-1:0] addr_d;
	logic [SCPR_ADDR_W-1:0] addr_next;

	// Address step per byte; the wrap at the bottom feeds the top address.
	always_comb begin
		addr_next = addr_q;
		if (lsb_first) begin
			addr_next = (addr_q == SCPR_TOP_ADDR) ? SCPR_BOT_ADDR : addr_q + SCPR_ADDR_ONE;
		end else begin
			addr_next = (addr_q == SCPR_BOT_ADDR) ? SCPR_TOP_ADDR : addr_q - SCPR_ADDR_ONE;
		end
	end

	always_comb begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		sh_d     = sh_q;
		wbyte_d  = wbyte_q;
		rd_d     = rd_q;
		stream_d = stream_q;
		left_d   = left_q;
		addr_d   = addr_q;
		wr_en    = 1'b0;
		wr_addr  = addr_q;
		wr_data  = wbyte_q;
		if (ce) begin
			if (cs_n_s) begin
				// A short transfer may stall on a byte boundary and resume later.
				if ((state_q == SCPR_ST_DONE) || (cnt_q[2:0] != SCPR_BYTE_BND) ||
				    ((state_q == SCPR_ST_DATA) && stream_q)) begin
					state_d = SCPR_ST_IDLE;
					cnt_d   = '0;
				end
			end else if (state_q == SCPR_ST_IDLE) begin
				state_d = SCPR_ST_INSTR;
				cnt_d   = '0;
			end else if (sclk_rise && (state_q == SCPR_ST_INSTR)) begin
				sh_d  = lsb_first ? {sdi_s, sh_q[15:1]} : {sh_q[14:0], sdi_s};
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == SCPR_INSTR_END) begin
					state_d  = SCPR_ST_DATA;
					cnt_d    = '0;
					rd_d     = sh_d[SCPR_RW_BIT];
					left_d   = sh_d[SCPR_LEN_HI:SCPR_LEN_LO];
					stream_d = (sh_d[SCPR_LEN_HI:SCPR_LEN_LO] == SCPR_LEN_STRM);
					// Upper three address bits are ignored; the host keeps them zero.
					addr_d   = sh_d[SCPR_ADDR_W-1:0];
				end
			end else if (sclk_rise && (state_q == SCPR_ST_DATA)) begin
				wbyte_d = lsb_first ? {sdi_s, wbyte_q[7:1]} : {wbyte_q[6:0], sdi_s};
				cnt_d   = {1'b0, cnt_q[2:0] + 3'h1};
				if (cnt_q[2:0] == SCPR_BYTE_END) begin
					cnt_d   = '0;
					wr_en   = !rd_q;
					wr_data = wbyte_d;
					addr_d  = addr_next;
					if (stream_q) begin
						if (addr_q == SCPR_TOP_ADDR) begin
							state_d = SCPR_ST_DONE;
						end
					end else if (left_q == SCPR_LEN_ONE) begin
						state_d = SCPR_ST_DONE;
					end else begin
						left_d = left_q - 2'h1;
					end
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= SCPR_ST_IDLE;
			cnt_q    <= '0;
			sh_q     <= '0;
			wbyte_q  <= '0;
			rd_q     <= 1'b0;
			stream_q <= 1'b0;
			left_q   <= '0;
			addr_q   <= '0;
		end else begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			sh_q     <= sh_d;
			wbyte_q  <= wbyte_d;
			rd_q     <= rd_d;
			stream_q <= stream_d;
			left_q   <= left_d;
			addr_q   <= addr_d;
		end
	end

	// ************************************************************
	// Readback drive
	// ************************************************************
	logic sdio_out_q;
	logic sdio_out_d;
	logic sdio_oe_n_q;
	logic sdio_oe_n_d;
	logic rbo_q;
	logic rbo_d;
	logic rbo_oe_n_q;
	logic rbo_oe_n_d;
	logic drive;
	logic rd_bit;

	// Drive only in a read data phase while selected; the enable lags one cycle.
	assign drive  = !cs_n_s && (state_q == SCPR_ST_DATA) && rd_q;
	assign rd_bit = lsb_first ? rd_data[cnt_q[2:0]] : rd_data[~cnt_q[2:0]];

	always_comb begin
		sdio_out_d  = sdio_out_q;
		sdio_oe_n_d = sdio_oe_n_q;
		rbo_d       = rbo_q;
		rbo_oe_n_d  = rbo_oe_n_q;
		if (ce) begin
			sdio_oe_n_d = !(drive && !separate_output_enable);
			rbo_oe_n_d  = !(drive && separate_output_enable);
			if (sclk_fall && drive) begin
				sdio_out_d = rd_bit;
				rbo_d      = rd_bit;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sdio_out_q  <= 1'b0;
			sdio_oe_n_q <= 1'b1;
			rbo_q       <= 1'b0;
			rbo_oe_n_q  <= 1'b1;
		end else begin
			sdio_out_q  <= sdio_out_d;
			sdio_oe_n_q <= sdio_oe_n_d;
			rbo_q       <= rbo_d;
			rbo_oe_n_q  <= rbo_oe_n_d;
		end
	end

	assign sdio_out          = sdio_out_q;
	assign sdio_oe_n         = sdio_oe_n_q;
	assign readback_out_pin  = rbo_q;
	assign readback_out_oe_n = rbo_oe_n_q;

endmodule : scpr_serial_port

/* shared/scpr_pkg.sv */
package scpr_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int             SCPR_ADDR_W    = 10;
	localparam int             SCPR_REG_COUNT = 563;
	localparam logic [9:0]     SCPR_CFG_ADDR  = 10'h000;
	localparam logic [9:0]     SCPR_RB_ADDR   = 10'h004;
	localparam logic [9:0]     SCPR_TOP_ADDR  = 10'h232;
	localparam logic [9:0]     SCPR_BOT_ADDR  = 10'h000;
	localparam logic [9:0]     SCPR_ADDR_ONE  = 10'h001;
	localparam logic [7:0]     SCPR_CFG_RESET = 8'h18;
	localparam logic [7:0]     SCPR_REG_RESET = 8'h00;
	localparam logic [7:0]     SCPR_RD_NONE   = 8'h00;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int             SCPR_CFG_SEP_BIT  = 0;
	localparam int             SCPR_CFG_LSB_BIT  = 1;
	localparam int             SCPR_CFG_LSB_MBIT = 6;
	localparam int             SCPR_RB_ACT_BIT   = 0;
	localparam int             SCPR_UPD_BIT      = 0;

	// ************************************************************
	// Instruction word
	// ************************************************************
	localparam int             SCPR_INSTR_W   = 16;
	localparam int             SCPR_RW_BIT    = 15;
	localparam int             SCPR_LEN_HI    = 14;
	localparam int             SCPR_LEN_LO    = 13;
	localparam logic [1:0]     SCPR_LEN_ONE   = 2'h0;
	localparam logic [1:0]     SCPR_LEN_STRM  = 2'h3;
	localparam logic [3:0]     SCPR_INSTR_END = 4'hF;
	localparam logic [2:0]     SCPR_BYTE_END  = 3'h7;
	localparam logic [2:0]     SCPR_BYTE_BND  = 3'h0;

	// ************************************************************
	// Port state machine
	// ************************************************************
	typedef enum logic [3:0] {
		SCPR_ST_IDLE  = 4'h1,
		SCPR_ST_INSTR = 4'h2,
		SCPR_ST_DATA  = 4'h4,
		SCPR_ST_DONE  = 4'h8
	} scpr_state_e;

endpackage : scpr_pkg

/* verilog/scpr_sync.sv */
`timescale 1ns/1ps

module scpr_sync #(
	parameter int         WIDTH = 1,
	parameter logic [0:0] INIT  = 1'b0
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             ce,
	// Asynchronous in, synchronous out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// The first stage feeds only the second stage.
	always_comb begin
		meta_d = ce ? async_in : meta_q;
		sync_d = ce ? meta_q : sync_q;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= {WIDTH{INIT}};
			sync_q <= {WIDTH{INIT}};
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule : scpr_sync

/* verilog/scpr_regfile.sv */
`timescale 1ns/1ps

module scpr_regfile #(
	parameter int DEPTH = scpr_pkg::SCPR_REG_COUNT
) (
	// Clock and reset
	input  wire logic                              clock,
	input  wire logic                              rst_n,
	input  wire logic                              ce,
	// Write port into the staging buffer
	input  wire logic                              wr_en,
	input  wire logic [scpr_pkg::SCPR_ADDR_W-1:0]  wr_addr,
	input  wire logic [7:0]                        wr_data,
	// Read port
	input  wire logic [scpr_pkg::SCPR_ADDR_W-1:0]  rd_addr,
	output logic      [7:0]                        rd_data,
	// Live port configuration
	output logic      [7:0]                        port_cfg
);
	import scpr_pkg::*;

	logic [7:0] buf_q [DEPTH];
	logic [7:0] act_q [DEPTH];
	logic       upd_q;
	logic       upd_d;
	logic       rb_active;

	// ************************************************************
	// Update request, taken one cycle after the write lands
	// ************************************************************
	always_comb begin
		upd_d = upd_q;
		if (ce) begin
			upd_d = wr_en && (wr_addr == SCPR_TOP_ADDR) && wr_data[SCPR_UPD_BIT];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			upd_q <= 1'b0;
		end else begin
			upd_q <= upd_d;
		end
	end

	// ************************************************************
	// Staged and active storage
	// ************************************************************
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_entry
			localparam logic [7:0] RST = (i == int'(SCPR_CFG_ADDR)) ? SCPR_CFG_RESET : SCPR_REG_RESET;
			logic [7:0] buf_d;
			logic [7:0] act_d;

			always_comb begin
				buf_d = buf_q[i];
				act_d = act_q[i];
				if (ce) begin
					if (upd_q) begin
						act_d = buf_q[i];
						if (i == int'(SCPR_TOP_ADDR)) begin
							act_d[SCPR_UPD_BIT] = 1'b0;
							buf_d[SCPR_UPD_BIT] = 1'b0;
						end
					end
					// A fresh write beats the self-clear of the update bit.
					if (wr_en && (wr_addr == SCPR_ADDR_W'(i))) begin
						buf_d = wr_data;
					end
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					buf_q[i] <= RST;
					act_q[i] <= RST;
				end else begin
					buf_q[i] <= buf_d;
					act_q[i] <= act_d;
				end
			end
		end
	endgenerate

	// ************************************************************
	// Readback source and live configuration
	// ************************************************************
	assign rb_active = buf_q[SCPR_RB_ADDR][SCPR_RB_ACT_BIT];
	// The port configuration acts from the buffer, so it needs no update.
	assign port_cfg  = buf_q[SCPR_CFG_ADDR];

	always_comb begin
		rd_data = SCPR_RD_NONE;
		if (rd_addr < SCPR_ADDR_W'(DEPTH)) begin
			rd_data = rb_active ? act_q[rd_addr] : buf_q[rd_addr];
		end
	end

endmodule : scpr_regfile

/* bench/scpr_sva.sv */
`timescale 1ns/1ps

module scpr_sva (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// Link pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdio_in,
	// Pin drives
	input wire logic sdio_out,
	input wire logic sdio_oe_n,
	input wire logic readback_out_pin,
	input wire logic readback_out_oe_n
);
	logic       sclk_q;
	logic [7:0] rise_cnt;

	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// Raw pin rises lead the synchronised ones, so the count is never behind the design.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q   <= 1'b0;
			rise_cnt <= 8'h00;
		end else begin
			sclk_q <= sclk;
			if (cs_n && sdio_oe_n && readback_out_oe_n)
				rise_cnt <= 8'h00;
			else if (sclk && !sclk_q && rise_cnt != 8'hFF)
				rise_cnt <= rise_cnt + 8'h01;
		end
	end

	property p_idle_float;
		cs_n [*6] |-> sdio_oe_n && readback_out_oe_n;
	endproperty
	a_idle_float: assert property (p_idle_float) else $error("pin driven while deselected");
	property p_release_end;
		$rose(cs_n) |-> ##[0:5] (sdio_oe_n && readback_out_oe_n);
	endproperty
	a_release_end: assert property (p_release_end) else $error("pin kept after frame end");
	property p_one_pin;
		sdio_oe_n || readback_out_oe_n;
	endproperty
	a_one_pin: assert property (p_one_pin) else $error("both pins driven");
	property p_shared_late;
		!sdio_oe_n |-> rise_cnt >= 8'h10;
	endproperty
	a_shared_late: assert property (p_shared_late) else $error("shared pin driven in instruction");
	property p_sep_late;
		!readback_out_oe_n |-> rise_cnt >= 8'h10;
	endproperty
	a_sep_late: assert property (p_sep_late) else $error("output pin driven in instruction");
	property p_bit_on_fall;
		sclk [*5] |-> $stable(sdio_out) && $stable(readback_out_pin);
	endproperty
	a_bit_on_fall: assert property (p_bit_on_fall) else $error("read bit moved while clock high");
	property p_shared_byte;
		$fell(sdio_oe_n) |=> !sdio_oe_n [*8];
	endproperty
	a_shared_byte: assert property (p_shared_byte) else $error("shared drive too short");
	property p_sep_byte;
		$fell(readback_out_oe_n) |=> !readback_out_oe_n [*8];
	endproperty
	a_sep_byte: assert property (p_sep_byte) else $error("output drive too short");

	c_shared_read: cover property ($rose(sdio_oe_n));
	c_sep_read: cover property ($fell(readback_out_oe_n));
	c_past_end: cover property (rise_cnt == 8'h30 && sdio_oe_n && !cs_n);
endmodule : scpr_sva

bind scpr_serial_port scpr_sva sva_u (
	.clock(clock), .rst_n(rst_n), .ce(ce), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
	.sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .readback_out_pin(readback_out_pin),
	.readback_out_oe_n(readback_out_oe_n)
);

/* bench/scpr_host.sv */
`timescale 1ns/1ps

module scpr_host (
	// Frame alignment
	input  wire logic clock,
	// Device drive
	input  wire logic sdio_out,
	input  wire logic sdio_oe_n,
	input  wire logic readback_out_pin,
	input  wire logic readback_out_oe_n,
	// Host drive
	output logic      sclk,
	output logic      cs_n,
	output logic      sdio_in
);
	logic       hd;
	logic       hoe;
	logic       lsb;
	logic       uni;
	logic [7:0] drv_cnt;
	logic [7:0] wr_b [0:2];
	logic [7:0] rd_b [0:3];

	// A released line shows the inverse of the last host bit, so a stale value never passes.
	assign sdio_in = !sdio_oe_n ? sdio_out : (hoe ? hd : ~hd);

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		hd   = 1'b0;
		hoe  = 1'b0;
		lsb  = 1'b0;
		uni  = 1'b0;
	end

	task automatic shift(input logic [7:0] v, input logic drv, output logic [7:0] r);
		for (int i = 0; i < 8; i++) begin
			hd  = v[lsb ? i : 7 - i];
			hoe = drv;
			#40 sclk = 1'b1;
			r[lsb ? i : 7 - i] = uni ? (readback_out_oe_n ? ~hd : readback_out_pin) : sdio_in;
			if (uni ? !readback_out_oe_n : !sdio_oe_n)
				drv_cnt++;
			#40 sclk = 1'b0;
		end
	endtask : shift

	task automatic xfer(input logic rd, input logic [1:0] len, input logic [9:0] a, input int n);
		logic [15:0] w;
		logic [7:0]  r;
		w       = {rd, len, 3'h0, a};
		drv_cnt = 8'h00;
		@(posedge clock);
		#1 cs_n = 1'b0;
		#40;
		shift(lsb ? w[7:0] : w[15:8], 1'b1, r);
		shift(lsb ? w[15:8] : w[7:0], 1'b1, r);
		for (int b = 0; b < n; b++) begin
			shift(rd ? 8'h00 : wr_b[b], !rd, r);
			rd_b[b] = r;
		end
		hoe = 1'b0;
		#40 cs_n = 1'b1;
		#40;
	endtask : xfer
endmodule : scpr_host

/* bench/serial_config_port_read_addr_tb.sv */
`timescale 1ns/1ps

module serial_config_port_read_addr_tb;
	import scpr_pkg::*;

	logic       clock;
	logic       rst_n;
	logic       sclk;
	logic       cs_n;
	logic       sdio_in;
	logic       sdio_out;
	logic       sdio_oe_n;
	logic       readback_out_pin;
	logic       readback_out_oe_n;
	logic [7:0] exp_b [0:2];
	int         n_mismatch;
	int         check_count;
	int         cyc;

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	scpr_serial_port dut_u (
		.clock(clock), .rst_n(rst_n), .ce(1'b1), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .readback_out_pin(readback_out_pin),
		.readback_out_oe_n(readback_out_oe_n)
	);
	scpr_host host_u (
		.clock(clock), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .readback_out_pin(readback_out_pin),
		.readback_out_oe_n(readback_out_oe_n)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic put(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
		exp_b[0]       = b0;
		exp_b[1]       = b1;
		exp_b[2]       = b2;
		host_u.wr_b[0] = b0;
		host_u.wr_b[1] = b1;
		host_u.wr_b[2] = b2;
	endtask : put

	// The count ndrv is the number of sampled bits that the device drove; it also sets how many bytes compare.
	task automatic frame(input logic rd, input logic [1:0] len, input logic [9:0] a, input int n,
			input logic [7:0] ndrv);
		host_u.xfer(rd, len, a, n);
		check(host_u.drv_cnt, ndrv);
		for (int i = 0; i < ndrv / 8; i++)
			check(host_u.rd_b[i], exp_b[i]);
	endtask : frame

	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	initial begin
		rst_n = 1'b0;
		repeat (10) @(posedge clock);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clock);
		put(8'h00, 8'h00, 8'h18);
		frame(1'b1, 2'h2, 10'h002, 3, 8'd24);
		$display("reset values done");
		put(8'hA1, 8'hB2, 8'hC3);
		frame(1'b0, 2'h2, 10'h012, 3, 8'd0);
		frame(1'b1, 2'h2, 10'h012, 3, 8'd24);
		put(8'hB2, 8'hC3, 8'h00);
		frame(1'b1, 2'h1, 10'h011, 2, 8'd16);
		put(8'hC3, 8'h00, 8'h00);
		frame(1'b1, 2'h0, 10'h010, 1, 8'd8);
		$display("counted transfers done");
		put(8'h01, 8'h00, 8'h00);
		frame(1'b0, 2'h0, SCPR_RB_ADDR, 1, 8'd0);
		put(8'h00, 8'h00, 8'h00);
		frame(1'b1, 2'h2, 10'h012, 3, 8'd24);
		put(8'h01, 8'h00, 8'h00);
		frame(1'b0, 2'h0, SCPR_TOP_ADDR, 1, 8'd0);
		put(8'hA1, 8'hB2, 8'hC3);
		frame(1'b1, 2'h2, 10'h012, 3, 8'd24);
		put(8'h00, 8'h00, 8'h00);
		frame(1'b1, 2'h0, SCPR_TOP_ADDR, 1, 8'd8);
		frame(1'b0, 2'h0, SCPR_RB_ADDR, 1, 8'd0);
		$display("readback source done");
		put(8'h5A, 8'h18, 8'h00);
		frame(1'b0, 2'h3, 10'h001, 2, 8'd0);
		frame(1'b1, 2'h3, 10'h001, 4, 8'd24);
		$display("decrement stream done");
		put(8'h5A, 8'h00, 8'h00);
		frame(1'b0, 2'h0, SCPR_CFG_ADDR, 1, 8'd0);
		host_u.lsb = 1'b1;
		put(8'h11, 8'h22, 8'h00);
		frame(1'b0, 2'h3, 10'h230, 3, 8'd0);
		frame(1'b1, 2'h3, 10'h230, 4, 8'd24);
		$display("increment stream done");
		put(8'hDB, 8'h00, 8'h00);
		frame(1'b0, 2'h0, SCPR_CFG_ADDR, 1, 8'd0);
		host_u.uni = 1'b1;
		put(8'h22, 8'h00, 8'h00);
		frame(1'b1, 2'h0, 10'h231, 1, 8'd8);
		put(8'h18, 8'h00, 8'h00);
		frame(1'b0, 2'h0, SCPR_CFG_ADDR, 1, 8'd0);
		host_u.lsb = 1'b0;
		host_u.uni = 1'b0;
		frame(1'b1, 2'h0, SCPR_CFG_ADDR, 1, 8'd8);
		$display("pin mode done");
		wrap_up();
	end
endmodule : serial_config_port_read_addr_tb
